// [design/dcti_interlock.sv]
// dual channel torque interlock: sync, self-check and power stage gating
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - enabled interlock takes general inputs three, four
// - drive only while both inputs high
// - self-check at power-on and each rise-to-both-high
// - outputs off until self-check passes
// - any low input disables outputs at once
// - single high input disables and flags fault
// - interlock off by default, strap turns on
// - only the motor drive is withheld
// - tripped outputs float the motor terminals
module dcti_interlock #(
  parameter int unsigned CHECK_CYCLES = dcti_pkg::SELFCHECK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic interlock_strap_i,
  input wire dcti_pkg::dcti_pair_t general_pins_i,
  input wire logic selfcheck_ok_i,
  input wire logic motor_cmd_enable_i,
  output logic selfcheck_pulse_o,
  output logic [1:0] general_inputs_o,
  output dcti_pkg::dcti_drive_t drive_o,
  output logic fault_o,
  output logic comms_enable_o,
  output logic interlock_active_o
);
  import dcti_pkg::*;

  // ****************************************
  // input synchronisers
  // ****************************************
  dcti_pair_t meta_q;
  dcti_pair_t sync_q;
  logic strap_meta_q;
  logic strap_q;

  // two flops per input; first stage read only by the second
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
      strap_meta_q <= 1'b0;
      strap_q <= 1'b0;
    end else begin
      meta_q <= general_pins_i;
      sync_q <= meta_q;
      strap_meta_q <= interlock_strap_i;
      strap_q <= strap_meta_q;
    end
  end

  // ****************************************
  // decode of the safety pair
  // ****************************************
  wire logic both_high;
  wire logic mismatch;
  wire logic active;
  logic both_high_q;
  logic powered_q;
  wire logic rise_both;

  assign active = strap_q;
  assign both_high = sync_q.in_a & sync_q.in_b;
  assign mismatch = sync_q.in_a ^ sync_q.in_b;
  // a rise is only counted once the first sample pair is valid
  assign rise_both = both_high & ~both_high_q & powered_q;

  // pins serve as general inputs only while the interlock is off
  assign general_inputs_o = active ? 2'b00 :
                            {sync_q.in_b, sync_q.in_a};
  assign interlock_active_o = active;
  assign comms_enable_o = 1'b1;

  // ****************************************
  // self-check sequencer
  // ****************************************
  dcti_state_t state_q;
  dcti_state_t state_d;
  logic [SELFCHECK_CNT_W-1:0] cnt_q;
  logic [SELFCHECK_CNT_W-1:0] cnt_d;
  logic passed_q;
  logic passed_d;
  wire logic cnt_done;

  // last check cycle; the counter starts from zero on entry
  assign cnt_done = cnt_q == SELFCHECK_CNT_W'(CHECK_CYCLES - 1);

  // next state: check on power-on and each entry to both high
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    passed_d = passed_q;
    case (state_q)
      DCTI_BLOCKED: begin
        cnt_d = CNT_RESET;
        if (powered_q && (!passed_q || rise_both)) begin
          state_d = DCTI_CHECKING;
        end
      end
      DCTI_CHECKING: begin
        cnt_d = cnt_q + 8'h01;
        if (cnt_done) begin
          passed_d = selfcheck_ok_i;
          state_d = (selfcheck_ok_i && both_high) ? DCTI_RUN :
                    DCTI_BLOCKED;
          cnt_d = CNT_RESET;
        end
      end
      DCTI_RUN: begin
        if (!both_high) begin
          state_d = DCTI_BLOCKED;
        end
      end
      default: begin
        state_d = DCTI_BLOCKED;
        cnt_d = CNT_RESET;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_q <= DCTI_BLOCKED;
      cnt_q <= CNT_RESET;
      passed_q <= 1'b0;
      both_high_q <= 1'b0;
      powered_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      passed_q <= passed_d;
      both_high_q <= both_high;
      powered_q <= 1'b1;
    end
  end

  // test stimulus into the interlock path while checking
  assign selfcheck_pulse_o = state_q == DCTI_CHECKING;

  // ****************************************
  // power stage gating
  // ****************************************
  wire logic allow;
  logic en_q;
  logic fault_q;

  // combinational cut on a low input, so no extra cycle of torque
  assign allow = ~active |
                 (both_high & state_q == DCTI_RUN & passed_q);
  assign drive_o.bridge_enable = en_q & allow & motor_cmd_enable_i;
  // no braking: low and high sides both released together
  assign drive_o.terminals_float = ~drive_o.bridge_enable;
  assign fault_o = fault_q;

  // registered enable and fault flag
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      en_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      en_q <= allow;
      fault_q <= active & mismatch;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_low_blocks;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (active && !both_high) |-> !drive_o.bridge_enable;
  endproperty
  a_low_blocks: assert property (p_low_blocks)
    else $error("drive enabled with a safety input low");

  property p_fault_flag;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (active && mismatch) |=> fault_o;
  endproperty
  a_fault_flag: assert property (p_fault_flag)
    else $error("mismatch not reported as fault");

  property p_no_fault_both_low;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (sync_q == 2'b00) |=> !fault_o;
  endproperty
  a_no_fault_both_low: assert property (p_no_fault_both_low)
    else $error("fault raised with both inputs low");

  property p_check_on_rise;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (active && rise_both && state_q != DCTI_CHECKING)
        |=> selfcheck_pulse_o;
  endproperty
  a_check_on_rise: assert property (p_check_on_rise)
    else $error("no self-check after entry to both high");

  property p_no_run_unchecked;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (active && !passed_q) |-> !drive_o.bridge_enable;
  endproperty
  a_no_run_unchecked: assert property (p_no_run_unchecked)
    else $error("drive enabled before self-check passed");

  property p_float;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (active && (!both_high || state_q != DCTI_RUN))
        |-> drive_o.terminals_float;
  endproperty
  a_float: assert property (p_float)
    else $error("terminals not floating while blocked");

  property p_gen_inputs;
    @(posedge mclk_i) disable iff (!reset_n_i)
      active |-> general_inputs_o == 2'b00;
  endproperty
  a_gen_inputs: assert property (p_gen_inputs)
    else $error("general inputs visible while interlock active");

  property p_sync;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $rose(general_pins_i.in_a) |-> ##1 !sync_q.in_a ##1 sync_q.in_a;
  endproperty
  a_sync: assert property (p_sync)
    else $error("synchroniser latency not two cycles");

  property p_comms;
    @(posedge mclk_i) disable iff (!reset_n_i) comms_enable_o;
  endproperty
  a_comms: assert property (p_comms)
    else $error("communication disabled by the interlock");

  property p_check_len;
    @(posedge mclk_i) disable iff (!reset_n_i)
      $rose(selfcheck_pulse_o) |-> selfcheck_pulse_o [*2];
  endproperty
  a_check_len: assert property (p_check_len)
    else $error("self-check shorter than two cycles");

  c_run: cover property (@(posedge mclk_i) state_q == DCTI_RUN);
  c_fault: cover property (@(posedge mclk_i) fault_o);
  c_trip: cover property (@(posedge mclk_i)
    state_q == DCTI_RUN ##1 state_q == DCTI_BLOCKED);
  c_recheck: cover property (@(posedge mclk_i) passed_q && rise_both);

endmodule

`default_nettype wire

// [design/dcti_pkg.sv]
// package of constants and carrier types for the torque interlock
package dcti_pkg;

  // ****************************************
  // self-check timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SELFCHECK_TIME_NS = 2000;
  localparam int unsigned SELFCHECK_CYCLES =
    (SELFCHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SELFCHECK_CNT_W = 8;
  localparam logic [7:0] CNT_RESET = 8'h00;

  // ****************************************
  // carrier types
  // ****************************************
  // raw safety pair as seen at the pins
  typedef struct packed {
    logic in_a;
    logic in_b;
  } dcti_pair_t;

  // drive permission towards the power stage
  typedef struct packed {
    logic bridge_enable;
    logic terminals_float;
  } dcti_drive_t;

  typedef enum logic [1:0] {
    DCTI_BLOCKED,
    DCTI_CHECKING,
    DCTI_RUN
  } dcti_state_t;

endpackage

// [sim/dcti_safety_src.sv]
// partner model: external safety circuit on the two redundant inputs
`timescale 1ns/1ps
`default_nettype none

module dcti_safety_src (
  input wire logic mclk_i,
  output var dcti_pkg::dcti_pair_t pins_o
);
  import dcti_pkg::*;

  // both lines start low, as an unplugged safety circuit would leave them
  initial pins_o = 2'h0;

  // levels change just after an edge, then hold until the next request
  task automatic set_pair(input logic a, input logic b);
    @(posedge mclk_i);
    #1;
    pins_o = {a, b};
  endtask
endmodule

`default_nettype wire

// [sim/tb_dual_channel_torque_interlock.sv]
// self-checking bench for the dual channel torque interlock
`timescale 1ns/1ps
`default_nettype none

module tb_dual_channel_torque_interlock;
  import dcti_pkg::*;
  // short self-check keeps the run brief
  localparam int unsigned CHK = 3;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic strap = 1'b0;
  logic ok = 1'b0;
  logic cmd = 1'b0;
  dcti_pair_t pins;
  dcti_drive_t drive;
  logic [1:0] gen;
  logic pulse, fault, comms, active;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int i;

  // 10 MHz clock
  always #50 mclk_i = ~mclk_i;

  dcti_safety_src u_dcti_safety_src (.mclk_i(mclk_i), .pins_o(pins));

  dcti_interlock #(.CHECK_CYCLES(CHK)) u_dcti_interlock (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .interlock_strap_i(strap),
    .general_pins_i(pins), .selfcheck_ok_i(ok),
    .motor_cmd_enable_i(cmd), .selfcheck_pulse_o(pulse),
    .general_inputs_o(gen), .drive_o(drive), .fault_o(fault),
    .comms_enable_o(comms), .interlock_active_o(active)
  );

  // ****************************************
  // helpers
  // ****************************************
  // inputs always move 1 ns after the edge so sampling is never racy
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // strap off: pins stay general inputs and drive follows the command
  task automatic t_bypass;
    u_dcti_safety_src.set_pair(1'b1, 1'b0);
    cmd = 1'b1;
    step(4);
    chk(gen, 2'h1);
    chk(active, 1'b0);
    chk(drive.bridge_enable, 1'b1);
    chk(comms, 1'b1);
    $display("t_bypass done");
  endtask

  // strap on, both high: drive only after a passing self-check
  task automatic t_enable;
    strap = 1'b1;
    ok = 1'b1;
    step(4);
    chk(active, 1'b1);
    chk(gen, 2'h0);
    u_dcti_safety_src.set_pair(1'b1, 1'b1);
    for (i = 0; i < 10 && pulse !== 1'b1; i++) step(1);
    chk(pulse, 1'b1);
    chk(drive.bridge_enable, 1'b0);
    for (i = 0; i < 10 && drive.bridge_enable !== 1'b1; i++) step(1);
    chk(drive.bridge_enable, 1'b1);
    chk(drive.terminals_float, 1'b0);
    cmd = 1'b0;
    step(1);
    chk(drive.bridge_enable, 1'b0);
    chk(drive.terminals_float, 1'b1);
    cmd = 1'b1;
    step(1);
    chk(drive.bridge_enable, 1'b1);
    $display("t_enable done");
  endtask

  // one channel drops: outputs off at once and mismatch flagged
  task automatic t_trip;
    u_dcti_safety_src.set_pair(1'b1, 1'b0);
    step(2);
    chk(drive.bridge_enable, 1'b0);
    chk(drive.terminals_float, 1'b1);
    step(1);
    chk(fault, 1'b1);
    chk(comms, 1'b1);
    u_dcti_safety_src.set_pair(1'b0, 1'b0);
    step(3);
    chk(fault, 1'b0);
    chk(drive.bridge_enable, 1'b0);
    // the other channel alone must raise the fault as well
    u_dcti_safety_src.set_pair(1'b0, 1'b1);
    step(3);
    chk(fault, 1'b1);
    chk(drive.bridge_enable, 1'b0);
    u_dcti_safety_src.set_pair(1'b0, 1'b0);
    step(3);
    chk(fault, 1'b0);
    $display("t_trip done");
  endtask

  // return to both high reruns the check; a failed check keeps it off
  task automatic t_recheck;
    ok = 1'b0;
    u_dcti_safety_src.set_pair(1'b1, 1'b1);
    for (i = 0; i < 10 && pulse !== 1'b1; i++) step(1);
    chk(pulse, 1'b1);
    step(CHK + 4);
    chk(drive.bridge_enable, 1'b0);
    $display("t_recheck done");
  endtask

  // a hang counts as a mismatch and ends the run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 1000) begin
      err_total++;
      end_sim();
    end
  end

  // reset for 3 cycles, then the scenarios in order
  initial begin
    step(3);
    reset_n_i = 1'b1;
    step(3);
    // power-on self-check is running two edges after release
    chk(pulse, 1'b1);
    t_bypass();
    t_enable();
    t_trip();
    t_recheck();
    end_sim();
  end
endmodule

`default_nettype wire
